// ===== rtl/lcdb_pkg.sv
package lcdb_pkg;

  // ----------------------------------------
  // Target address and byte layout
  // ----------------------------------------
  localparam logic [5:0] TGT_ADDR_HI = 6'h1c;
  localparam int STRAP_BIT = 1;
  localparam int DIR_BIT = 0;
  localparam int CONT_BIT = 7;
  localparam int OP_HI = 6;
  localparam int OP_LO = 5;
  localparam int BANK_IN_BIT = 1;
  localparam int BANK_OUT_BIT = 0;
  localparam logic [3:0] ACK_BITCNT = 4'h8;
  localparam logic [3:0] BITCNT_ONE = 4'h1;
  localparam int NUM_COLS = 32;
  localparam int NUM_ROWS = 4;
  localparam int BYTE_BITS = 8;
  localparam logic [1:0] BANK_ROW_OFS = 2'h2;

  // ----------------------------------------
  // Command opcodes in bits 6:5
  // ----------------------------------------
  localparam logic [1:0] OP_LOAD_PTR = 2'h0;
  localparam logic [1:0] OP_DEV_SEL = 2'h1;
  localparam logic [1:0] OP_MODE_SET = 2'h2;
  localparam logic [1:0] OP_BANK_SEL = 2'h3;

  // ----------------------------------------
  // Drive modes and reset values
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_STATIC = 2'h0,
    MODE_MUX2 = 2'h1,
    MODE_MUX3 = 2'h2,
    MODE_MUX4 = 2'h3
  } lcdb_mode_e;
  localparam lcdb_mode_e MODE_RESET = MODE_MUX4;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [2:0] SUB_RESET = 3'h0;

  // ----------------------------------------
  // Link timing of the controller end
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [6:0] QTR_LAST = 7'(SCL_QTR_CYC - 1);

  // ----------------------------------------
  // Event word passed from link to display side
  // ----------------------------------------
  typedef struct packed {
    logic isWrite;
    logic [4:0] ptr;
    logic inBank;
    lcdb_mode_e mode;
    logic outBank;
    logic [7:0] data;
  } lcdb_evt_s;

  // Rows used per column in each mode
  function automatic logic [2:0] modeRows(input lcdb_mode_e m);
    case (m)
      MODE_STATIC: modeRows = 3'h1;
      MODE_MUX2: modeRows = 3'h2;
      MODE_MUX3: modeRows = 3'h3;
      default: modeRows = 3'h4;
    endcase
  endfunction

  // Pointer step after each stored byte
  function automatic logic [3:0] modeStep(input lcdb_mode_e m);
    case (m)
      MODE_STATIC: modeStep = 4'h8;
      MODE_MUX2: modeStep = 4'h4;
      MODE_MUX3: modeStep = 4'h3;
      default: modeStep = 4'h2;
    endcase
  endfunction

  // Bank switching exists only in static and 1:2
  function automatic logic bankOk(input lcdb_mode_e m);
    bankOk = (m == MODE_STATIC) || (m == MODE_MUX2);
  endfunction

endpackage

// ===== rtl/lcdb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lcdb_if;
  // Open-drain drivers of both parties
  logic ctrlSclOut;
  logic ctrlSclOe;
  logic ctrlSdaOut;
  logic ctrlSdaOe;
  logic tgtSdaOut;
  logic tgtSdaOe;
  // Resolved wired-AND bus levels
  logic scl;
  logic sda;
  assign scl = !(ctrlSclOe && !ctrlSclOut);
  assign sda = !((ctrlSdaOe && !ctrlSdaOut) || (tgtSdaOe && !tgtSdaOut));

  modport tgt (input scl, input sda, output tgtSdaOut, output tgtSdaOe);
  modport ctrl (input scl, input sda, output ctrlSclOut, output ctrlSclOe,
                output ctrlSdaOut, output ctrlSdaOe);
endinterface
`default_nettype wire

// ===== rtl/lcdb_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module lcdb_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lcdb_sync_s;
  lcdb_sync_s st_q;
  lcdb_sync_s st_d;

  // Second stage alone reads the first
  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule
`default_nettype wire

// ===== rtl/lcdb_target.sv
`timescale 1ns/1ps
`default_nettype none
module lcdb_target (
  // Link clock domain
  input wire logic linkClk,
  input wire logic rstLink,
  // Display clock domain
  input wire logic clk,
  input wire logic rst,
  // Bus
  lcdb_if.tgt bus,
  // Straps
  input wire logic targetAddressStrap,
  input wire logic hwSubaddressBit0,
  input wire logic hwSubaddressBit1,
  input wire logic hwSubaddressBit2,
  // Display side
  input wire logic muxStep,
  output logic [1:0] muxPos,
  output logic [1:0] rowSel,
  output logic [31:0] segData
);
  // ----------------------------------------
  // Link side: receiver on the link clock
  // ----------------------------------------
  typedef enum logic [3:0] {
    L_IDLE = 4'b0001,
    L_ADDR = 4'b0010,
    L_CMD = 4'b0100,
    L_DATA = 4'b1000
  } lcdb_lstate_e;

  typedef struct packed {
    logic sclP;
    logic sdaP;
    lcdb_lstate_e st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic ackPh;
    logic ackOe;
    logic [4:0] ptr;
    logic [2:0] subCnt;
    lcdb_pkg::lcdb_mode_e mode;
    logic inBank;
    logic outBank;
    lcdb_pkg::lcdb_evt_s evt;
    logic evtTgl;
  } lcdb_lnk_s;

  lcdb_lnk_s lnk_q;
  lcdb_lnk_s lnk_d;
  logic [5:0] pinS;
  logic sclS;
  logic sdaS;
  logic sclLowS;
  logic sdaLowS;
  logic strapS;
  logic [2:0] hwSubS;
  logic rise;
  logic fall;
  logic startC;
  logic stopC;
  logic [5:0] ptrSum;
  logic [7:0] byteIn;
  logic subMatch;

  // Pins pass two flops; bus lines kept inverted so a cleared synchroniser reads idle
  lcdb_sync2 #(.W(6)) u_pinSync (
    .clk(linkClk),
    .rst(rstLink),
    .d({!bus.scl, !bus.sda, targetAddressStrap, hwSubaddressBit2, hwSubaddressBit1,
        hwSubaddressBit0}),
    .q(pinS)
  );
  assign {sclLowS, sdaLowS, strapS, hwSubS} = pinS;
  assign sclS = !sclLowS;
  assign sdaS = !sdaLowS;

  // Bus conditions and byte engine
  always_comb begin
    lnk_d = lnk_q;
    lnk_d.sclP = sclS;
    lnk_d.sdaP = sdaS;
    rise = sclS && !lnk_q.sclP;
    fall = !sclS && lnk_q.sclP;
    startC = sclS && lnk_q.sclP && lnk_q.sdaP && !sdaS;
    stopC = sclS && lnk_q.sclP && !lnk_q.sdaP && sdaS;
    byteIn = lnk_q.shift;
    subMatch = (lnk_q.subCnt == hwSubS);
    ptrSum = {1'b0, lnk_q.ptr} + {2'b00, lcdb_pkg::modeStep(lnk_q.mode)};
    if (startC || stopC) begin
      lnk_d.st = startC ? L_ADDR : L_IDLE;
      lnk_d.bitCnt = '0;
      lnk_d.ackPh = 1'b0;
      lnk_d.ackOe = 1'b0;
    end else if (lnk_q.st != L_IDLE) begin
      if (rise && !lnk_q.ackPh && lnk_q.bitCnt != lcdb_pkg::ACK_BITCNT) begin
        lnk_d.shift = {lnk_q.shift[6:0], sdaS};
        lnk_d.bitCnt = lnk_q.bitCnt + lcdb_pkg::BITCNT_ONE;
      end else if (fall && lnk_q.ackPh) begin
        lnk_d.ackPh = 1'b0;
        lnk_d.ackOe = 1'b0;
        lnk_d.bitCnt = '0;
      end else if (fall && lnk_q.bitCnt == lcdb_pkg::ACK_BITCNT) begin
        lnk_d.ackPh = 1'b1;
        case (lnk_q.st)
          L_ADDR: begin
            if (byteIn[7:2] == lcdb_pkg::TGT_ADDR_HI &&
                byteIn[lcdb_pkg::STRAP_BIT] == strapS &&
                !byteIn[lcdb_pkg::DIR_BIT]) begin
              lnk_d.st = L_CMD;
              lnk_d.ackOe = 1'b1;
            end else begin
              lnk_d.st = L_IDLE;
              lnk_d.ackPh = 1'b0;
            end
          end
          L_CMD: begin
            lnk_d.ackOe = 1'b1;
            case (byteIn[lcdb_pkg::OP_HI:lcdb_pkg::OP_LO])
              lcdb_pkg::OP_LOAD_PTR: lnk_d.ptr = byteIn[4:0];
              lcdb_pkg::OP_DEV_SEL: lnk_d.subCnt = byteIn[2:0];
              lcdb_pkg::OP_MODE_SET: lnk_d.mode = lcdb_pkg::lcdb_mode_e'(byteIn[1:0]);
              default: begin
                lnk_d.inBank = byteIn[lcdb_pkg::BANK_IN_BIT];
                lnk_d.outBank = byteIn[lcdb_pkg::BANK_OUT_BIT];
              end
            endcase
            if (!byteIn[lcdb_pkg::CONT_BIT]) begin
              lnk_d.st = L_DATA;
            end
            lnk_d.evt = '{1'b0, lnk_d.ptr, lnk_d.inBank, lnk_d.mode, lnk_d.outBank, byteIn};
            lnk_d.evtTgl = !lnk_q.evtTgl;
          end
          L_DATA: begin
            lnk_d.ackOe = subMatch;
            lnk_d.ptr = ptrSum[4:0];
            if (ptrSum[5]) begin
              lnk_d.subCnt = lnk_q.subCnt + 3'h1;
            end
            lnk_d.evt = '{subMatch, lnk_q.ptr, lnk_q.inBank, lnk_q.mode, lnk_q.outBank,
                          byteIn};
            lnk_d.evtTgl = !lnk_q.evtTgl;
          end
          default: lnk_d.st = L_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge linkClk) begin
    if (rstLink) begin
      lnk_q <= '{1'b1, 1'b1, L_IDLE, 4'h0, 8'h00, 1'b0, 1'b0, lcdb_pkg::PTR_RESET,
                 lcdb_pkg::SUB_RESET, lcdb_pkg::MODE_RESET, 1'b0, 1'b0, '0, 1'b0};
    end else begin
      lnk_q <= lnk_d;
    end
  end

  assign bus.tgtSdaOut = 1'b0;
  assign bus.tgtSdaOe = lnk_q.ackOe;

  // ----------------------------------------
  // Display side: RAM and row selection
  // ----------------------------------------
  typedef struct packed {
    logic tglP;
    lcdb_pkg::lcdb_mode_e mode;
    logic outBank;
    logic [lcdb_pkg::NUM_COLS-1:0][lcdb_pkg::NUM_ROWS-1:0] ram;
    logic [1:0] pos;
    logic [1:0] row;
    logic [31:0] seg;
  } lcdb_dsp_s;

  lcdb_dsp_s dsp_q;
  lcdb_dsp_s dsp_d;
  logic tglS;

  // Event toggle crosses into display clock
  lcdb_sync2 #(.W(1)) u_tglSync (
    .clk(clk),
    .rst(rst),
    .d(lnk_q.evtTgl),
    .q(tglS)
  );

  // RAM write, multiplex stepping, row mux
  always_comb begin
    logic [4:0] c;
    logic [2:0] r;
    logic [2:0] rows;
    logic [1:0] base;
    dsp_d = dsp_q;
    c = lnk_q.evt.ptr;
    r = 3'h0;
    rows = lcdb_pkg::modeRows(lnk_q.evt.mode);
    base = (lnk_q.evt.inBank && lcdb_pkg::bankOk(lnk_q.evt.mode)) ?
           lcdb_pkg::BANK_ROW_OFS : 2'h0;
    dsp_d.tglP = tglS;
    if (tglS != dsp_q.tglP) begin
      dsp_d.mode = lnk_q.evt.mode;
      dsp_d.outBank = lnk_q.evt.outBank;
      if (lnk_q.evt.isWrite) begin
        for (int j = 0; j < lcdb_pkg::BYTE_BITS; j++) begin
          dsp_d.ram[c][r[1:0] + base] = lnk_q.evt.data[lcdb_pkg::BYTE_BITS-1-j];
          r = r + 3'h1;
          if (r == rows) begin
            r = 3'h0;
            c = c + 5'h01;
          end
        end
      end
    end
    rows = lcdb_pkg::modeRows(dsp_q.mode);
    if ({1'b0, dsp_q.pos} >= rows - 3'h1) begin
      dsp_d.pos = muxStep ? 2'h0 : (({1'b0, dsp_q.pos} >= rows) ? 2'h0 : dsp_q.pos);
    end else if (muxStep) begin
      dsp_d.pos = dsp_q.pos + 2'h1;
    end
    dsp_d.row = dsp_d.pos + ((dsp_q.outBank && lcdb_pkg::bankOk(dsp_q.mode)) ?
                             lcdb_pkg::BANK_ROW_OFS : 2'h0);
    for (int k = 0; k < lcdb_pkg::NUM_COLS; k++) begin
      dsp_d.seg[k] = dsp_q.ram[k][dsp_d.row];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dsp_q <= '{1'b0, lcdb_pkg::MODE_RESET, 1'b0, '0, 2'h0, 2'h0, 32'h0};
    end else begin
      dsp_q <= dsp_d;
    end
  end

  assign muxPos = dsp_q.pos;
  assign rowSel = dsp_q.row;
  assign segData = dsp_q.seg;
endmodule
`default_nettype wire

// ===== rtl/lcdb_controller.sv
`timescale 1ns/1ps
`default_nettype none
module lcdb_controller (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  lcdb_if.ctrl bus,
  // Byte requests
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] cmdByte,
  input wire logic cmdStart,
  input wire logic cmdStop,
  // Byte results
  output logic doneValid,
  output logic ackOk
);
  typedef enum logic [5:0] {
    C_IDLE = 6'b000001,
    C_START = 6'b000010,
    C_BIT = 6'b000100,
    C_ACK = 6'b001000,
    C_STOP = 6'b010000,
    C_WAIT = 6'b100000
  } lcdb_cstate_e;

  typedef struct packed {
    lcdb_cstate_e st;
    logic [1:0] ph;
    logic [6:0] qCnt;
    logic [7:0] sh;
    logic [2:0] bitCnt;
    logic stopAfter;
    logic sclLo;
    logic sdaLo;
    logic done;
    logic ack;
  } lcdb_ctl_s;

  lcdb_ctl_s c_q;
  lcdb_ctl_s c_d;
  logic [1:0] lineS;
  logic tick;
  logic busFree;
  logic take;

  // Bus lines pass two flops, held inverted so a cleared synchroniser reads idle
  lcdb_sync2 #(.W(2)) u_lineSync (
    .clk(clk),
    .rst(rst),
    .d({!bus.scl, !bus.sda}),
    .q(lineS)
  );

  assign busFree = !lineS[1] && !lineS[0];
  assign cmdReady = (c_q.st == C_IDLE && busFree) || c_q.st == C_WAIT;
  assign take = cmdValid && cmdReady;
  assign tick = (c_q.qCnt == lcdb_pkg::QTR_LAST);

  // Quarter-period sequencer
  always_comb begin
    c_d = c_q;
    c_d.done = 1'b0;
    if (c_q.st == C_IDLE || c_q.st == C_WAIT) begin
      c_d.qCnt = 7'h00;
      if (take) begin
        c_d.sh = cmdByte;
        c_d.stopAfter = cmdStop;
        c_d.bitCnt = 3'h0;
        c_d.ph = 2'h0;
        c_d.st = (c_q.st == C_IDLE || cmdStart) ? C_START : C_BIT;
      end
    end else begin
      c_d.qCnt = tick ? 7'h00 : c_q.qCnt + 7'h01;
      if (tick) begin
        c_d.ph = c_q.ph + 2'h1;
        if (c_q.st == C_ACK && c_q.ph == 2'h2) begin
          c_d.ack = lineS[0];
        end
        if (c_q.ph == 2'h3) begin
          case (c_q.st)
            C_START: c_d.st = C_BIT;
            C_BIT: begin
              c_d.sh = {c_q.sh[6:0], 1'b0};
              c_d.bitCnt = c_q.bitCnt + 3'h1;
              if (c_q.bitCnt == 3'h7) begin
                c_d.st = C_ACK;
              end
            end
            C_ACK: begin
              c_d.done = 1'b1;
              c_d.st = c_q.stopAfter ? C_STOP : C_WAIT;
            end
            default: c_d.st = C_IDLE;
          endcase
        end
      end
    end
    case (c_d.st)
      C_START: begin
        c_d.sclLo = (c_d.ph == 2'h0) || (c_d.ph == 2'h3);
        c_d.sdaLo = c_d.ph[1];
      end
      C_BIT: begin
        c_d.sclLo = (c_d.ph == 2'h0) || (c_d.ph == 2'h3);
        c_d.sdaLo = !c_d.sh[7];
      end
      C_ACK: begin
        c_d.sclLo = (c_d.ph == 2'h0) || (c_d.ph == 2'h3);
        c_d.sdaLo = 1'b0;
      end
      C_STOP: begin
        c_d.sclLo = (c_d.ph == 2'h0);
        c_d.sdaLo = !c_d.ph[1];
      end
      C_WAIT: begin
        c_d.sclLo = 1'b1;
        c_d.sdaLo = 1'b0;
      end
      default: begin
        c_d.sclLo = 1'b0;
        c_d.sdaLo = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      c_q <= '{C_IDLE, 2'h0, 7'h00, 8'h00, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      c_q <= c_d;
    end
  end

  // Open-drain drive, low only
  assign bus.ctrlSclOut = 1'b0;
  assign bus.ctrlSclOe = c_q.sclLo;
  assign bus.ctrlSdaOut = 1'b0;
  assign bus.ctrlSdaOe = c_q.sdaLo;
  assign doneValid = c_q.done;
  assign ackOk = c_q.ack;
endmodule
`default_nettype wire

// ===== dv/lcdb_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lcdb_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // Target drivers
  input wire logic tgtSdaOut,
  input wire logic tgtSdaOe
);
  // ----------------------------------------
  // Sampling and bus conditions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Data line falls or rises while the clock line stays high
  sequence startSeq;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stopSeq;
    scl && $past(scl) && $rose(sda);
  endsequence

  // ----------------------------------------
  // Controller framing
  // ----------------------------------------
  stop_leaves_idle_a: assert property (stopSeq |-> (scl && sda) [*8])
    else $error("bus not idle after stop");
  start_then_low_a: assert property (startSeq |-> ##[1:70] !scl)
    else $error("clock not pulled low after start");
  start_from_high_a: assert property (startSeq |-> $past(scl, 50))
    else $error("start without clock high beforehand");
  clock_low_phase_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");

  // ----------------------------------------
  // Target acknowledge
  // ----------------------------------------
  ack_pull_only_a: assert property (tgtSdaOe |-> !tgtSdaOut)
    else $error("target drives data line high");
  ack_rise_low_a: assert property ($rose(tgtSdaOe) |-> !scl)
    else $error("acknowledge starts while clock high");
  ack_holds_low_a: assert property (tgtSdaOe && scl |-> !sda)
    else $error("data line not low during acknowledge");
  ack_drop_low_a: assert property ($fell(tgtSdaOe) |-> !scl)
    else $error("acknowledge released while clock high");
  ack_length_a: assert property ($rose(tgtSdaOe) |-> tgtSdaOe [*8] ##[1:400] !tgtSdaOe)
    else $error("acknowledge length out of range");
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, linkClk, rst, rstLink, muxStep;
  logic cmdValid, cmdReady, cmdStart, cmdStop, doneValid, ackOk;
  logic [7:0] cmdByte;
  logic [1:0] muxPos, rowSel;
  logic [31:0] segData;
  int mismatches = 0;
  int totalChecks = 0;
  int cycles = 0;

  // Both ends joined by the bus, checker beside it
  lcdb_if i_lcdb_if ();
  lcdb_controller i_lcdb_controller (.clk(clk), .rst(rst), .bus(i_lcdb_if.ctrl),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdByte(cmdByte), .cmdStart(cmdStart),
    .cmdStop(cmdStop), .doneValid(doneValid), .ackOk(ackOk));
  lcdb_target i_lcdb_target (.linkClk(linkClk), .rstLink(rstLink), .clk(clk), .rst(rst),
    .bus(i_lcdb_if.tgt), .targetAddressStrap(1'b0), .hwSubaddressBit0(1'b1),
    .hwSubaddressBit1(1'b0), .hwSubaddressBit2(1'b1), .muxStep(muxStep),
    .muxPos(muxPos), .rowSel(rowSel), .segData(segData));
  lcdb_asserts i_lcdb_asserts (.clk(clk), .rst(rst), .scl(i_lcdb_if.scl),
    .sda(i_lcdb_if.sda), .tgtSdaOut(i_lcdb_if.tgtSdaOut), .tgtSdaOe(i_lcdb_if.tgtSdaOe));

  // ----------------------------------------
  // Clocks and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #3;
    forever #16 linkClk = ~linkClk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      giveVerdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One byte through the controller, acknowledge compared
  task automatic sendByte(input logic [7:0] b, input logic st, input logic sp,
                          input logic expAck);
    int n;
    cmdValid <= 1'b1;
    cmdByte <= b;
    cmdStart <= st;
    cmdStop <= sp;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 5000);
    if (n >= 5000) mismatches++;
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (doneValid !== 1'b1 && n < 5000);
    if (n >= 5000) mismatches++;
    check({31'h0, ackOk}, {31'h0, expAck});
  endtask

  // Let the display side settle, step the multiplexer once, compare outputs
  task automatic viewStep(input logic [1:0] p, input logic [1:0] r, input logic [31:0] s);
    repeat (40) @(posedge clk);
    muxStep <= 1'b1;
    @(posedge clk);
    muxStep <= 1'b0;
    @(posedge clk);
    check({30'h0, muxPos}, {30'h0, p});
    check({30'h0, rowSel}, {30'h0, r});
    check(segData, s);
  endtask

  // Counts and verdict, then stop
  task automatic giveVerdict();
    $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    rstLink = 1'b1;
    muxStep = 1'b0;
    cmdValid = 1'b0;
    cmdByte = 8'h00;
    cmdStart = 1'b0;
    cmdStop = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge linkClk);
    rstLink <= 1'b0;
    repeat (20) @(posedge clk);
    // Static mode, subaddress 5, pointer 0, two data bytes
    sendByte(8'h70, 1'b1, 1'b0, 1'b1);
    sendByte(8'hc0, 1'b0, 1'b0, 1'b1);
    sendByte(8'ha5, 1'b0, 1'b0, 1'b1);
    sendByte(8'h00, 1'b0, 1'b0, 1'b1);
    sendByte(8'h12, 1'b0, 1'b0, 1'b1);
    sendByte(8'h34, 1'b0, 1'b1, 1'b1);
    viewStep(2'h0, 2'h0, 32'h00002c48);
    // Bank 1 written and shown in static mode
    sendByte(8'h70, 1'b1, 1'b0, 1'b1);
    sendByte(8'he3, 1'b0, 1'b0, 1'b1);
    sendByte(8'h00, 1'b0, 1'b0, 1'b1);
    sendByte(8'h56, 1'b0, 1'b1, 1'b1);
    viewStep(2'h0, 2'h2, 32'h0000006a);
    // 1:2 mode, write bank 0 while bank 1 is shown
    sendByte(8'h70, 1'b1, 1'b0, 1'b1);
    sendByte(8'hc1, 1'b0, 1'b0, 1'b1);
    sendByte(8'he1, 1'b0, 1'b0, 1'b1);
    sendByte(8'h00, 1'b0, 1'b0, 1'b1);
    sendByte(8'h9c, 1'b0, 1'b1, 1'b1);
    viewStep(2'h1, 2'h3, 32'h00000000);
    viewStep(2'h0, 2'h2, 32'h0000006a);
    // 1:4 mode, subaddress mismatch then pointer wrap into a match
    sendByte(8'h70, 1'b1, 1'b0, 1'b1);
    sendByte(8'hc3, 1'b0, 1'b0, 1'b1);
    sendByte(8'he0, 1'b0, 1'b0, 1'b1);
    sendByte(8'ha4, 1'b0, 1'b0, 1'b1);
    sendByte(8'h1f, 1'b0, 1'b0, 1'b1);
    sendByte(8'hff, 1'b0, 1'b0, 1'b0);
    sendByte(8'h80, 1'b0, 1'b1, 1'b1);
    viewStep(2'h1, 2'h1, 32'h00000000);
    viewStep(2'h2, 2'h2, 32'h00000068);
    viewStep(2'h3, 2'h3, 32'h00000000);
    viewStep(2'h0, 2'h0, 32'h00002c43);
    // Wrong strap bit and read direction are ignored
    sendByte(8'h72, 1'b1, 1'b0, 1'b0);
    sendByte(8'hc0, 1'b0, 1'b1, 1'b0);
    sendByte(8'h71, 1'b1, 1'b1, 1'b0);
    viewStep(2'h1, 2'h1, 32'h00000000);
    giveVerdict();
  end
endmodule
`default_nettype wire
